// ### dcf_params.svh
// Constants of the DAC control block and its host controller
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// Link field codes
`define DCF_DEST_SPECIAL 2'h0
`define DCF_DEST_B 2'h2
`define DCF_DEST_A 2'h3
`define DCF_CTRL_ADDR 5'h0C
`define DCF_MON_ADDR 5'h0D
`define DCF_PWRUP_ADDR 5'h0E
`define DCF_MON_OFF 6'h3F

// Control word bit positions
`define DCF_TG_LO 0
`define DCF_MON_EN 5
`define DCF_THERM_EN 6
`define DCF_REF_SRC 8
`define DCF_REF_LVL 10
`define DCF_CTRL_W 11

// Power-on brownout window
`define DCF_BROWNOUT_MS 10
`define DCF_CLK_KHZ 20000
`define DCF_BROWNOUT_CYC (`DCF_BROWNOUT_MS * `DCF_CLK_KHZ)

// Host register offsets
`define DCF_OFF_CMD 8'h00
`define DCF_OFF_ACT 8'h04
`define DCF_OFF_STAT 8'h08
`define DCF_OFF_IRQ_STAT 8'h0C
`define DCF_OFF_IRQ_CLR 8'h10
`define DCF_OFF_IRQ_EN 8'h14
`define DCF_IRQ_W 3

`endif

// ### dcf_pkg.sv
// Types shared by the DAC control block and its host controller
package dcf_pkg;
    typedef enum logic [0:0] {DCF_INIT, DCF_RUN} dcf_phase_t;
endpackage

// ### dcf_link_if.sv
// Link between the host controller and the DAC control block
`timescale 1ns/1ps
`default_nettype none
interface dcf_link_if;
    logic wr;
    logic dest_select_hi;
    logic dest_select_lo;
    logic [4:0] channel_address;
    logic [11:0] wdata;
    logic output_update_strobe;
    logic dev_reset;
    logic [11:0] monitor_output;
    logic monitor_oe;
    logic dev_ready;
    logic amp_on;

    modport dev (
        input wr, dest_select_hi, dest_select_lo, channel_address, wdata,
        input output_update_strobe, dev_reset,
        output monitor_output, monitor_oe, dev_ready, amp_on
    );
    modport host (
        output wr, dest_select_hi, dest_select_lo, channel_address, wdata,
        output output_update_strobe, dev_reset,
        input monitor_output, monitor_oe, dev_ready, amp_on
    );
endinterface
`default_nettype wire

// ### dcf_chan_group.sv
// One group of eight channels with A/B registers and toggle
`timescale 1ns/1ps
`default_nettype none
module dcf_chan_group #(
    parameter int W = 12,
    parameter int N = 8
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Writes
    input wire logic wr_a_in,
    input wire logic wr_b_in,
    input wire logic [$clog2(N)-1:0] idx_in,
    input wire logic [W-1:0] data_in,
    // Control
    input wire logic toggle_en_in,
    input wire logic update_in,
    // Output codes
    output logic [N*W-1:0] code_out
);
    typedef struct packed {
        logic [N-1:0][W-1:0] a;
        logic [N-1:0][W-1:0] b;
        logic [N-1:0][W-1:0] out;
        logic phase_b;
    } dcf_grp_t;

    dcf_grp_t s_r;
    dcf_grp_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_a_in) begin
            s_nxt.a[idx_in] = data_in;
        end
        if (wr_b_in && toggle_en_in) begin
            s_nxt.b[idx_in] = data_in;
        end
        if (!toggle_en_in) begin
            s_nxt.phase_b = 1'b0;
        end
        if (update_in) begin
            if (toggle_en_in && s_r.phase_b) begin
                s_nxt.out = s_r.b;
            end else begin
                s_nxt.out = s_r.a;
            end
            if (toggle_en_in) begin
                s_nxt.phase_b = ~s_r.phase_b;
            end
        end
        if (srst_in) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge mclk_in) begin
        s_r <= s_nxt;
    end

    assign code_out = s_r.out;
endmodule
`default_nettype wire

// ### dcf_device.sv
// DAC control block: control word, channels, monitor, thermal, init
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
module dcf_device
    import dcf_pkg::*;
#(
    parameter int W = 12,
    parameter int CHANNELS = 32,
    parameter int GROUP = 8,
    parameter int unsigned BROWNOUT_CYCLES = `DCF_BROWNOUT_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Host link
    dcf_link_if.dev link,
    // Pins
    input wire logic over_temp_in,
    input wire logic fifo_enable_in,
    input wire logic par_select_in,
    // Analog-side controls
    output logic [CHANNELS*W-1:0] dac_code_out,
    output logic amp_enable_out,
    output logic ref_internal_out,
    output logic ref_level_out,
    output logic fifo_active_out
);
    localparam int GROUPS = CHANNELS / GROUP;
    localparam int GW = $clog2(GROUP);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        dcf_phase_t phase;
        logic [31:0] cnt;
        logic ot_s1;
        logic ot_s2;
        logic fe_s1;
        logic fe_s2;
        logic ps_s1;
        logic ps_s2;
        logic [`DCF_CTRL_W-1:0] ctrl;
        logic [5:0] mon_sel;
        logic amp_on;
        logic fifo_on;
        logic [W-1:0] mon;
        logic mon_oe;
        logic ready;
    } dcf_dev_t;

    dcf_dev_t s_r;
    dcf_dev_t s_nxt;

    logic [CHANNELS-1:0][W-1:0] codes;
    logic [1:0] dest;
    logic run_wr;
    logic special_function_write;
    logic wr_a;
    logic wr_b;
    logic grp_rst;
    logic over_temp;

    // -------------------------------------------------------------
    // Write decode
    // -------------------------------------------------------------
    assign dest = {link.dest_select_hi, link.dest_select_lo};
    assign run_wr = link.wr && (s_r.phase == DCF_RUN);
    assign special_function_write = run_wr
        && (dest == `DCF_DEST_SPECIAL);
    assign wr_a = run_wr && (dest == `DCF_DEST_A);
    assign wr_b = run_wr && (dest == `DCF_DEST_B);
    assign grp_rst = srst_in || link.dev_reset;
    assign over_temp = s_r.ot_s2;

    // -------------------------------------------------------------
    // Channel groups
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : grp
            logic sel;
            assign sel = (link.channel_address[4:GW] == (5-GW)'(g));
            dcf_chan_group #(
                .W(W),
                .N(GROUP)
            ) u_grp (
                .mclk_in(mclk_in),
                .srst_in(grp_rst),
                .wr_a_in(wr_a && sel),
                .wr_b_in(wr_b && sel),
                .idx_in(link.channel_address[GW-1:0]),
                .data_in(link.wdata),
                .toggle_en_in(s_r.ctrl[`DCF_TG_LO + g]),
                .update_in(link.output_update_strobe),
                .code_out(codes[g*GROUP +: GROUP])
            );
        end
    endgenerate

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.ot_s1 = over_temp_in;
        s_nxt.ot_s2 = s_r.ot_s1;
        s_nxt.fe_s1 = fifo_enable_in;
        s_nxt.fe_s2 = s_r.fe_s1;
        s_nxt.ps_s1 = par_select_in;
        s_nxt.ps_s2 = s_r.ps_s1;

        // Initialization and brownout window
        case (s_r.phase)
            DCF_INIT: begin
                s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                if (s_r.cnt >= 32'(BROWNOUT_CYCLES - 1)) begin
                    s_nxt.phase = DCF_RUN;
                    s_nxt.ready = 1'b1;
                    s_nxt.fifo_on = s_r.fe_s2 && s_r.ps_s2;
                end
            end
            DCF_RUN: begin
                s_nxt.cnt = s_r.cnt;
            end
            default: begin
                s_nxt.phase = DCF_INIT;
            end
        endcase

        // Special function writes
        if (special_function_write) begin
            case (link.channel_address)
                `DCF_CTRL_ADDR: begin
                    s_nxt.ctrl = link.wdata[`DCF_CTRL_W-1:0];
                end
                `DCF_MON_ADDR: begin
                    if (s_r.ctrl[`DCF_MON_EN]) begin
                        s_nxt.mon_sel = link.wdata[5:0];
                    end
                end
                `DCF_PWRUP_ADDR: begin
                    if (!over_temp) begin
                        s_nxt.amp_on = 1'b1;
                    end
                end
                default: begin
                    s_nxt.mon_sel = s_nxt.mon_sel;
                end
            endcase
        end

        // Thermal guard
        if (!s_r.ctrl[`DCF_THERM_EN]) begin
            s_nxt.amp_on = 1'b1;
        end else if (over_temp) begin
            s_nxt.amp_on = 1'b0;
        end

        // Channel monitor
        if (s_r.ctrl[`DCF_MON_EN] && s_r.mon_sel != `DCF_MON_OFF
            && s_r.mon_sel < 6'(CHANNELS)) begin
            s_nxt.mon_oe = 1'b1;
            s_nxt.mon = codes[s_r.mon_sel[4:0]];
        end else begin
            s_nxt.mon_oe = 1'b0;
            s_nxt.mon = '0;
        end

        // Reset: external reference, all bits clear except monitor select (off) and amplifiers (on)
        if (grp_rst) begin
            s_nxt = '0;
            s_nxt.phase = DCF_INIT;
            s_nxt.mon_sel = `DCF_MON_OFF;
            s_nxt.amp_on = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        s_r <= s_nxt;
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign dac_code_out = codes;
    assign amp_enable_out = s_r.amp_on;
    assign ref_internal_out = s_r.ctrl[`DCF_REF_SRC];
    assign ref_level_out = s_r.ctrl[`DCF_REF_LVL];
    assign fifo_active_out = s_r.fifo_on;
    assign link.monitor_output = s_r.mon;
    assign link.monitor_oe = s_r.mon_oe;
    assign link.dev_ready = s_r.ready;
    assign link.amp_on = s_r.amp_on;
endmodule
`default_nettype wire

// ### dcf_host.sv
// Host controller: APB registers driving the DAC control link
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
module dcf_host
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Interrupt
    output logic irq_out,
    // Device link
    dcf_link_if.host link
);
    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic pend;
        logic [18:0] cmd;
        logic wr;
        logic upd;
        logic dev_rst;
        logic [`DCF_IRQ_W-1:0] stat;
        logic [`DCF_IRQ_W-1:0] en;
        logic irq;
        logic prev_ready;
        logic prev_amp;
    } dcf_host_t;

    dcf_host_t s_r;
    dcf_host_t s_nxt;
    logic acc;
    logic [`DCF_IRQ_W-1:0] ev;

    assign acc = psel_in && penable_in && !s_r.pready;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = acc;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = '0;
        s_nxt.wr = 1'b0;
        s_nxt.upd = 1'b0;
        s_nxt.dev_rst = 1'b0;
        s_nxt.prev_ready = link.dev_ready;
        s_nxt.prev_amp = link.amp_on;
        ev = '0;

        // Command issue, one write per pulse
        if (s_r.pend && link.dev_ready && !s_r.wr) begin
            s_nxt.wr = 1'b1;
            s_nxt.pend = 1'b0;
            ev[2] = 1'b1;
        end

        if (acc) begin
            case (paddr_in)
                `DCF_OFF_CMD: begin
                    if (pwrite_in && s_r.pend) begin
                        s_nxt.pslverr = 1'b1;
                    end else if (pwrite_in) begin
                        s_nxt.cmd = pwdata_in[18:0];
                        s_nxt.pend = 1'b1;
                    end
                    s_nxt.prdata = {13'h0000, s_r.cmd};
                end
                `DCF_OFF_ACT: begin
                    if (pwrite_in) begin
                        s_nxt.upd = pwdata_in[0];
                        s_nxt.dev_rst = pwdata_in[1];
                        s_nxt.pend = s_nxt.pend && !pwdata_in[1];
                    end
                end
                `DCF_OFF_STAT: begin
                    s_nxt.prdata = {4'h0, link.monitor_output, 12'h000,
                        s_r.pend, link.monitor_oe, link.amp_on,
                        link.dev_ready};
                end
                `DCF_OFF_IRQ_STAT: begin
                    s_nxt.prdata = {29'h0000_0000, s_r.stat};
                end
                `DCF_OFF_IRQ_CLR: begin
                    s_nxt.prdata = '0;
                end
                `DCF_OFF_IRQ_EN: begin
                    if (pwrite_in) begin
                        s_nxt.en = pwdata_in[`DCF_IRQ_W-1:0];
                    end
                    s_nxt.prdata = {29'h0000_0000, s_r.en};
                end
                default: begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end

        // Events: shutdown seen, device ready, write issued
        ev[0] = s_r.prev_amp && !link.amp_on;
        ev[1] = !s_r.prev_ready && link.dev_ready;
        s_nxt.stat = s_r.stat;
        if (acc && pwrite_in && paddr_in == `DCF_OFF_IRQ_CLR) begin
            s_nxt.stat = s_r.stat & ~pwdata_in[`DCF_IRQ_W-1:0];
        end
        s_nxt.stat = s_nxt.stat | ev;
        s_nxt.irq = |(s_nxt.stat & s_nxt.en);

        if (srst_in) begin
            s_nxt = '0;
            s_nxt.prev_amp = 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        s_r <= s_nxt;
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign irq_out = s_r.irq;
    assign link.wr = s_r.wr;
    assign link.dest_select_hi = s_r.cmd[18];
    assign link.dest_select_lo = s_r.cmd[17];
    assign link.channel_address = s_r.cmd[16:12];
    assign link.wdata = s_r.cmd[11:0];
    assign link.output_update_strobe = s_r.upd;
    assign link.dev_reset = s_r.dev_rst;
endmodule
`default_nettype wire

// ### dcf_link_asserts.sv
// Assertions on the link between host controller and DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
module dcf_link_asserts (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic srst_in,
    // Link signals
    input wire logic wr,
    input wire logic dest_select_hi,
    input wire logic dest_select_lo,
    input wire logic [4:0] channel_address,
    input wire logic [11:0] wdata,
    input wire logic output_update_strobe,
    input wire logic dev_reset,
    input wire logic [11:0] monitor_output,
    input wire logic monitor_oe,
    input wire logic dev_ready,
    input wire logic amp_on
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (srst_in);
    // ----------------------------------------
    // Special function writes taken by device
    // ----------------------------------------
    logic special_function_write;
    logic ctl;
    assign special_function_write = wr && dev_ready && !dest_select_hi
        && !dest_select_lo;
    assign ctl = special_function_write
        && channel_address == `DCF_CTRL_ADDR;
    chk_wr_spacing: assert property (wr |=> !wr)
        else $error("link writes too close");
    chk_wr_ready: assert property (wr |-> dev_ready)
        else $error("link write during init");
    chk_strobe_pulse: assert property
        (output_update_strobe |=> !output_update_strobe)
        else $error("update strobe longer than one cycle");
    chk_reset_init: assert property (dev_reset |=> !dev_ready)
        else $error("device reset did not restart init");
    chk_ready_holds: assert property
        (dev_ready && !dev_reset |=> dev_ready)
        else $error("ready dropped without reset");
    chk_mon_gate: assert property
        (ctl && !wdata[5] |=> ##1 !monitor_oe)
        else $error("monitor driven while disabled");
    chk_mon_off: assert property
        (special_function_write && channel_address == `DCF_MON_ADDR
        && wdata[5:0] == `DCF_MON_OFF |=> ##1 !monitor_oe)
        else $error("monitor not three-stated");
    chk_mon_idle: assert property
        (!monitor_oe |-> monitor_output == 12'h000)
        else $error("monitor code while off");
    chk_guard_off: assert property
        (ctl && !wdata[6] |=> ##[0:1] amp_on)
        else $error("amplifiers off with guard cleared");
endmodule
`default_nettype wire

// ### test_dac_control_features.sv
// Testbench of the host controller and DAC control block pair
`timescale 1ns/1ps
`default_nettype none
`include "dcf_params.svh"
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin \
    failures++; $display("CHECK FAILED %0t %s", $time, m); end end
module test_dac_control_features import dcf_pkg::*;;
    logic mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, ot = 1'b0, fen = 1'b1, par = 1'b1, sl;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, amp, ref_int, ref_lvl, fifo;
    logic [383:0] code;
    logic [11:0] va, vb;
    int failures = 0, cmp_count = 0, cyc = 0, c;
    always #25 mclk = ~mclk;
    dcf_link_if link ();
    dcf_host u_dcf_host (.mclk_in(mclk), .srst_in(srst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq), .link(link.host));
    dcf_device #(.BROWNOUT_CYCLES(8)) u_dcf_device (.mclk_in(mclk),
        .srst_in(srst), .link(link.dev), .over_temp_in(ot),
        .fifo_enable_in(fen), .par_select_in(par), .dac_code_out(code),
        .amp_enable_out(amp), .ref_internal_out(ref_int),
        .ref_level_out(ref_lvl), .fifo_active_out(fifo));
    dcf_link_asserts u_dcf_link_asserts (.mclk_in(mclk), .srst_in(srst),
        .wr(link.wr), .dest_select_hi(link.dest_select_hi),
        .dest_select_lo(link.dest_select_lo),
        .channel_address(link.channel_address), .wdata(link.wdata),
        .output_update_strobe(link.output_update_strobe),
        .dev_reset(link.dev_reset), .monitor_output(link.monitor_output),
        .monitor_oe(link.monitor_oe), .dev_ready(link.dev_ready),
        .amp_on(link.amp_on));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic send(input logic [1:0] dst, input logic [4:0] a,
            input logic [11:0] d);
        apb(1'b1, `DCF_OFF_CMD, {13'h0000, dst, a, d});
        rd = 32'h0000_0008;
        while (rd[3] !== 1'b0) apb(1'b0, `DCF_OFF_STAT, 32'h0000_0000);
        repeat (2) @(posedge mclk);
    endtask
    task automatic ctrl(input logic [11:0] d);
        send(2'b00, `DCF_CTRL_ADDR, d);
    endtask
    task automatic strobe;
        apb(1'b1, `DCF_OFF_ACT, 32'h0000_0001);
        repeat (3) @(posedge mclk);
    endtask
    task automatic wait_ready;
        rd = 32'h0000_0000;
        while (rd[0] !== 1'b1) apb(1'b0, `DCF_OFF_STAT, 32'h0000_0000);
    endtask
    task automatic end_sim;
        $display("Compares %0d, failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim;
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        wait_ready;
        `CHK(rd[3:0], 4'h3, "status after init")
        `CHK({ref_int, ref_lvl}, 2'b00, "external reference")
        `CHK(fifo, 1'b1, "fifo sampled at init")
        apb(1'b0, `DCF_OFF_IRQ_STAT, 32'h0000_0000);
        `CHK({rd[1], irq}, 2'b10, "ready event masked")
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK(sl, 1'b1, "unmapped offset refused")
        send(2'b11, `DCF_CTRL_ADDR, 12'h500);
        `CHK({ref_int, ref_lvl}, 2'b00, "channel write kept control")
        ctrl(12'h500);
        `CHK({ref_int, ref_lvl}, 2'b11, "internal 2.5 V")
        ctrl(12'h100);
        `CHK({ref_int, ref_lvl}, 2'b10, "internal 1.25 V")
        $display("Test control done");
        for (int g = 0; g < 4; g++) begin
            c = g * 8 + 1;
            va = {10'h040, g[1:0]};
            vb = {10'h080, g[1:0]};
            ctrl(12'h001 << g);
            send(2'b11, c[4:0], va);
            send(2'b10, c[4:0], vb);
            ctrl(12'h000);
            send(2'b10, c[4:0], 12'hEEE);
            ctrl(12'h001 << g);
            strobe;
            `CHK(code[c*12 +: 12], va, "first strobe gives A")
            strobe;
            `CHK(code[c*12 +: 12], vb, "second strobe gives B")
            ctrl(12'h000);
            strobe;
            `CHK(code[c*12 +: 12], va, "A after disable")
        end
        $display("Test toggle done");
        `CHK(code[144 +: 12], 12'h500, "channel 12 write kept")
        send(2'b00, `DCF_MON_ADDR, 12'h001);
        `CHK(link.monitor_oe, 1'b0, "select ignored while off")
        ctrl(12'h020);
        send(2'b00, `DCF_MON_ADDR, 12'h001);
        `CHK(link.monitor_oe, 1'b1, "ch1 driven")
        `CHK(link.monitor_output, 12'h100, "ch1 shown")
        ctrl(12'h000);
        `CHK(link.monitor_oe, 1'b0, "disable three-states")
        ctrl(12'h020);
        `CHK(link.monitor_oe, 1'b1, "selection kept")
        send(2'b00, `DCF_MON_ADDR, 12'h03F);
        `CHK(link.monitor_oe, 1'b0, "three-state")
        `CHK(link.monitor_output, 12'h000, "no code when off")
        $display("Test monitor done");
        ot <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(amp, 1'b1, "guard off keeps amps")
        apb(1'b1, `DCF_OFF_IRQ_EN, 32'h0000_0001);
        ctrl(12'h040);
        `CHK({amp, irq}, 2'b01, "shutdown raises interrupt")
        send(2'b00, `DCF_PWRUP_ADDR, 12'h000);
        `CHK(amp, 1'b0, "power-up refused while hot")
        ot <= 1'b0;
        repeat (6) @(posedge mclk);
        send(2'b00, `DCF_PWRUP_ADDR, 12'h000);
        `CHK(amp, 1'b1, "power-up after cooling")
        apb(1'b1, `DCF_OFF_IRQ_CLR, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b0, "interrupt cleared")
        ot <= 1'b1;
        repeat (6) @(posedge mclk);
        `CHK(amp, 1'b0, "hot with guard on")
        ctrl(12'h000);
        `CHK(amp, 1'b1, "guard cleared restores")
        $display("Test thermal done");
        ot <= 1'b0;
        fen <= 1'b0;
        repeat (4) @(posedge mclk);
        `CHK(fifo, 1'b1, "pin change ignored")
        fen <= 1'b1;
        par <= 1'b0;
        apb(1'b1, `DCF_OFF_ACT, 32'h0000_0002);
        apb(1'b1, `DCF_OFF_CMD, 32'h0004_0123);
        apb(1'b1, `DCF_OFF_CMD, 32'h0004_0456);
        `CHK(sl, 1'b1, "command refused while pending")
        repeat (3) @(posedge mclk);
        wait_ready;
        `CHK(fifo, 1'b0, "no fifo in serial mode")
        $display("Test fifo done");
        end_sim;
    end
endmodule
`default_nettype wire
